// [include/bmol_pkg.sv]
// Constants and types shared by the boot mode and option loader.
package bmol_pkg;
  localparam logic [31:0] SINGLE_VEC     = 32'hFFFF_FFFC;
  localparam logic [31:0] USER_VEC       = 32'hFF7F_FFFC;
  // Entry point of the factory serial loader; the value is arbitrary.
  localparam logic [31:0] SERIAL_VEC     = 32'hFFFF_0000;
  localparam logic [31:0] USER_BOOT_BYTES = 32'h0000_4000;
  localparam logic [31:0] ENDIAN_ADDR    = 32'hFFFF_FF80;
  localparam logic [31:0] SUP_OPT_ADDR   = 32'hFFFF_FF88;
  localparam logic [31:0] WDT_OPT_ADDR   = 32'hFFFF_FF8C;
  localparam logic [31:0] SYSCTL_OFF     = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFF     = 32'h0000_0004;
  localparam logic [31:0] WDT_OPT_OFF    = 32'h0000_0008;
  localparam logic [31:0] SUP_OPT_OFF    = 32'h0000_000C;
  localparam int          ROM_EN_BIT     = 0;
  localparam int          EXT_BUS_BIT    = 1;
  localparam logic        ROM_EN_RST     = 1'b1;
  localparam logic        EXT_BUS_RST    = 1'b0;
  localparam logic [31:0] OPT_WORD_RST   = 32'hFFFF_FFFF;
  localparam int          IND_WDT_START_BIT = 1;
  localparam int          IND_WDT_SET_LSB   = 2;
  localparam int          WDT_START_BIT     = 17;
  localparam int          WDT_SET_LSB       = 18;
  localparam int          LV_MON_BIT        = 2;
  localparam int          FAST_OSC_BIT      = 8;
  localparam logic [2:0]  ENDIAN_BIG     = 3'h0;
  localparam logic [1:0]  SETTLE_CYC     = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {BM_SINGLE, BM_SERIAL, BM_USER} bmol_mode_t;

  typedef struct packed {
    bmol_mode_t  mode;
    logic [31:0] start_vec;
    logic        boot_area_wr_en;
    logic        big_endian;
    logic        done;
  } bmol_boot_t;

  typedef struct packed {
    logic        ind_wdt_start;
    logic [14:0] ind_wdt_set;
    logic        wdt_start;
    logic [13:0] wdt_set;
    logic        lv_mon_on;
    logic        fast_osc_on;
  } bmol_opt_t;
endpackage

// [logic/bmol_loader.sv]
// Boot mode and option loader: strap sampling, option word fetch and system control bits.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// RQ1 - Boot mode from mode-select and boot-option pins.
// RQ2 - Mode-select high: single-chip, reset vector start.
// RQ3 - Both low: serial boot, loader may program.
// RQ4 - Select low, option high: user boot vector.
// RQ5 - Separate 16KB user boot area holds loader.
// RQ6 - After reset ROM enable 1, bus 0.
// RQ7 - ROM enable clear disables on-chip flash.
// RQ8 - External bus enable bit enables external bus.
// RQ9 - Cleared ROM enable cannot be set again.
// RQ10 - Option words read at boot set behaviour.
// RQ11 - Option word may autostart independent watchdog.
// RQ12 - Option word may autostart main watchdog.
// RQ13 - Supply word may enable voltage monitor zero.
// RQ14 - Option word powers fast oscillator or not.
// RQ15 - Endian word sets data endianness from boot.
// RQ16 - Programmer writes unused option bits as one.
// RQ17 - Programmer stores user boot codes first.
// RQ18 - Emulator overrides mode and option pin levels.
// RQ19 - Debug enable low; emulator drives it high.
// RQ20 - Pins sampled once at reset release.
module bmol_loader (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                boot_mode_select_pin,
  input  wire logic                boot_option_port_pin,
  input  wire logic                debug_enable_pin,
  output logic                     opt_rd,
  output logic [31:0]              opt_addr,
  input  wire logic [31:0]         opt_rdata,
  input  wire logic                opt_rvalid,
  output bmol_pkg::bmol_boot_t     boot_cfg,
  output bmol_pkg::bmol_opt_t      opt_cfg,
  output logic                     onchip_rom_enable,
  output logic                     external_bus_enable
);
  import bmol_pkg::*;

  typedef enum logic [2:0] {ST_SETTLE, ST_STRAP, ST_RD_WDT, ST_RD_SUP, ST_RD_END, ST_DONE} bmol_state_t;

  // An option feature is on when its bit is programmed to zero, so blank flash keeps it off.
  function automatic logic opt_on(input logic [31:0] w, input int b);
    opt_on = ~w[b];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0]  sel_s;
  logic [2:0]  po_s;
  logic [2:0]  de_s;
  bmol_state_t state_r;
  logic [1:0]  settle_r;
  logic [31:0] wdt_word_r;
  logic [31:0] sup_word_r;
  logic [31:0] end_word_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic [31:0] rd_nxt;
  logic        rd_ok;
  logic        wr_fire;
  logic        wr_ok;
  logic        rom_en_nxt;

  // Pin inputs pass three flops; a strap level counts once the second and third agree, debug is read from the third alone.
  always_ff @(posedge mclk) begin
    sel_s <= {sel_s[1:0], boot_mode_select_pin};
    po_s <= {po_s[1:0], boot_option_port_pin};
    de_s <= {de_s[1:0], debug_enable_pin};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Boot sequence: settle, latch straps, then fetch the three option words.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r  <= ST_SETTLE;
      settle_r <= '0;
      opt_rd   <= 1'b0;
      opt_addr <= '0;
    end else begin
      case (state_r)
        ST_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == SETTLE_CYC) begin
            state_r <= ST_STRAP;
          end
        end
        ST_STRAP: begin
          if (sel_s[1] == sel_s[2] && po_s[1] == po_s[2]) begin
            state_r  <= ST_RD_WDT;
            opt_rd   <= 1'b1;
            opt_addr <= WDT_OPT_ADDR;
          end
        end
        ST_RD_WDT: begin
          if (opt_rvalid) begin
            state_r  <= ST_RD_SUP;
            opt_addr <= SUP_OPT_ADDR;
          end
        end
        ST_RD_SUP: begin
          if (opt_rvalid) begin
            state_r  <= ST_RD_END;
            opt_addr <= ENDIAN_ADDR;
          end
        end
        ST_RD_END: begin
          if (opt_rvalid) begin
            state_r <= ST_DONE;
            opt_rd  <= 1'b0;
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_SETTLE;
        end
      endcase
    end
  end

  // Option words are caught as they arrive; all-ones means every feature off.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdt_word_r <= OPT_WORD_RST;
      sup_word_r <= OPT_WORD_RST;
      end_word_r <= OPT_WORD_RST;
    end else if (opt_rvalid) begin
      if (state_r == ST_RD_WDT) begin
        wdt_word_r <= opt_rdata; // RQ10
      end
      if (state_r == ST_RD_SUP) begin
        sup_word_r <= opt_rdata; // RQ10
      end
      if (state_r == ST_RD_END) begin
        end_word_r <= opt_rdata; // RQ10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Boot mode is latched once per reset and then frozen.
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_cfg <= '{mode: BM_SINGLE, start_vec: SINGLE_VEC, default: 1'b0};
    end else if (state_r == ST_STRAP && sel_s[1] == sel_s[2] && po_s[1] == po_s[2]) begin // RQ20
      if (sel_s[2]) begin // RQ1
        boot_cfg.mode      <= BM_SINGLE; // RQ2
        boot_cfg.start_vec <= SINGLE_VEC; // RQ2
      end else if (!po_s[2]) begin
        boot_cfg.mode            <= BM_SERIAL; // RQ3
        boot_cfg.start_vec       <= SERIAL_VEC; // RQ3
        boot_cfg.boot_area_wr_en <= 1'b1; // RQ5
      end else begin
        boot_cfg.mode      <= BM_USER; // RQ4
        boot_cfg.start_vec <= USER_VEC; // RQ4
      end
    end else if (state_r == ST_RD_END && opt_rvalid) begin
      boot_cfg.big_endian <= (opt_rdata[2:0] == ENDIAN_BIG); // RQ15
      boot_cfg.done       <= 1'b1;
    end
  end

  // Watchdog, monitor and oscillator enables go out together when the last word lands.
  always_ff @(posedge mclk) begin
    if (rst) begin
      opt_cfg <= '0;
    end else if (state_r == ST_RD_END && opt_rvalid) begin
      opt_cfg.ind_wdt_start <= opt_on(wdt_word_r, IND_WDT_START_BIT); // RQ11
      opt_cfg.ind_wdt_set   <= wdt_word_r[IND_WDT_SET_LSB +: 15]; // RQ11
      opt_cfg.wdt_start     <= opt_on(wdt_word_r, WDT_START_BIT); // RQ12
      opt_cfg.wdt_set       <= wdt_word_r[WDT_SET_LSB +: 14]; // RQ12
      opt_cfg.lv_mon_on     <= opt_on(sup_word_r, LV_MON_BIT); // RQ13
      opt_cfg.fast_osc_on   <= opt_on(sup_word_r, FAST_OSC_BIT); // RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order, answer follows both.
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ok   = (aw_addr_r == SYSCTL_OFF) || (aw_addr_r == STATUS_OFF)
                || (aw_addr_r == WDT_OPT_OFF) || (aw_addr_r == SUP_OPT_OFF) || (aw_addr_r == ENDIAN_ADDR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb_r      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  // Once cleared, the ROM enable can only stay clear until the next reset.
  assign rom_en_nxt = onchip_rom_enable & w_data_r[ROM_EN_BIT]; // RQ9

  always_ff @(posedge mclk) begin
    if (rst) begin
      onchip_rom_enable   <= ROM_EN_RST; // RQ6
      external_bus_enable <= EXT_BUS_RST; // RQ6
    end else if (wr_fire && aw_addr_r == SYSCTL_OFF && w_strb_r[0]) begin
      onchip_rom_enable   <= rom_en_nxt; // RQ7
      external_bus_enable <= w_data_r[EXT_BUS_BIT]; // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle answer after the address is taken.
  always_comb begin
    rd_nxt = '0;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      SYSCTL_OFF:  rd_nxt = {30'h0, external_bus_enable, onchip_rom_enable};
      STATUS_OFF:  rd_nxt = {25'h0, external_bus_enable, onchip_rom_enable, de_s[2],
                             boot_cfg.big_endian, boot_cfg.done, boot_cfg.mode};
      WDT_OPT_OFF: rd_nxt = wdt_word_r;
      SUP_OPT_OFF: rd_nxt = sup_word_r;
      ENDIAN_ADDR: rd_nxt = end_word_r;
      default:     rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_nxt;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  rom_after_reset_a: assert property ($fell(rst) |-> onchip_rom_enable && !external_bus_enable) // RQ6
    else $error("control bits wrong after reset");
  rom_stays_off_a: assert property (!onchip_rom_enable |=> !onchip_rom_enable) // RQ9
    else $error("rom enable set again after clear");
  rom_clear_a: assert property (wr_fire && aw_addr_r == SYSCTL_OFF && w_strb_r[0] && !w_data_r[ROM_EN_BIT]
                                |=> !onchip_rom_enable) // RQ7
    else $error("rom enable not cleared");
  ext_bus_a: assert property (wr_fire && aw_addr_r == SYSCTL_OFF && w_strb_r[0]
                              |=> external_bus_enable == $past(w_data_r[EXT_BUS_BIT])) // RQ8
    else $error("external bus enable wrong");
  strap_single_a: assert property (state_r == ST_STRAP && sel_s[2] && sel_s[1]
                                   |=> boot_cfg.mode == BM_SINGLE && boot_cfg.start_vec == SINGLE_VEC) // RQ2
    else $error("single-chip mode not taken");
  strap_serial_a: assert property (state_r == ST_STRAP && sel_s[2:1] == 2'h0 && po_s[2:1] == 2'h0
                                   |=> boot_cfg.mode == BM_SERIAL && boot_cfg.boot_area_wr_en) // RQ3
    else $error("serial boot not taken");
  strap_user_a: assert property (state_r == ST_STRAP && sel_s[2:1] == 2'h0 && po_s[2:1] == 2'h3
                                 |=> boot_cfg.mode == BM_USER && boot_cfg.start_vec == USER_VEC) // RQ4
    else $error("user boot not taken");
  mode_frozen_a: assert property (state_r != ST_SETTLE && state_r != ST_STRAP |=> $stable(boot_cfg.mode)) // RQ20
    else $error("boot mode changed after latch");
  endian_set_a: assert property (boot_cfg.done |-> boot_cfg.big_endian == (end_word_r[2:0] == ENDIAN_BIG)) // RQ15
    else $error("endianness does not match word");
  opt_apply_a: assert property (boot_cfg.done |-> opt_cfg.lv_mon_on == !sup_word_r[LV_MON_BIT]
                                && opt_cfg.fast_osc_on == !sup_word_r[FAST_OSC_BIT]
                                && opt_cfg.ind_wdt_start == !wdt_word_r[IND_WDT_START_BIT]
                                && opt_cfg.wdt_start == !wdt_word_r[WDT_START_BIT]) // RQ11
    else $error("option enables do not match words");

  boot_done_c: cover property (boot_cfg.done && opt_cfg.ind_wdt_start);
  rom_off_c: cover property (!onchip_rom_enable && external_bus_enable);
  user_boot_c: cover property (boot_cfg.done && boot_cfg.mode == BM_USER);
endmodule

// [testbench/bmol_board_model.sv]
// Board straps, debug emulator and option flash seen from the boot loader.
`timescale 1ns/1ns
module bmol_board_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        emu_on,
  input  wire logic        board_sel,
  input  wire logic        board_opt,
  input  wire logic        emu_sel,
  input  wire logic        emu_opt,
  input  wire logic [31:0] wdt_word,
  input  wire logic [31:0] sup_word,
  input  wire logic [31:0] end_word,
  input  wire logic [3:0]  dly,
  input  wire logic        opt_rd,
  input  wire logic [31:0] opt_addr,
  output logic             boot_mode_select_pin,
  output logic             boot_option_port_pin,
  output logic             debug_enable_pin,
  output logic [31:0]      opt_rdata,
  output logic             opt_rvalid
);
  import bmol_pkg::*;
  logic [3:0] wait_r;
  // User boot codes sit in the option area for the user boot run; the loader never fetches them.
  // Both values are arbitrary.
  localparam logic [31:0] USER_CODE_ADDR = 32'hFFFF_FF90;
  localparam logic [31:0] USER_CODE_WORD = 32'h3C3C_C3C3;
  ////////////////////////////////////////
  assign boot_mode_select_pin = emu_on ? emu_sel : board_sel;
  assign boot_option_port_pin = emu_on ? emu_opt : board_opt;
  // The board pull-down keeps debug low; an attached emulator raises it for the whole session.
  assign debug_enable_pin = emu_on;
  function automatic logic [31:0] word_at(input logic [31:0] a);
    case (a)
      WDT_OPT_ADDR: word_at = wdt_word;
      SUP_OPT_ADDR: word_at = sup_word;
      ENDIAN_ADDR: word_at = end_word;
      USER_CODE_ADDR: word_at = USER_CODE_WORD;
      default: word_at = 32'hFFFF_FFFF;
    endcase
  endfunction
  // Outside a valid pulse the data lines toggle, so stale data can never pass for a real read.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_r <= 4'h0;
      opt_rvalid <= 1'b0;
      opt_rdata <= 32'h5A5A_A5A5;
    end else if (!opt_rd || opt_rvalid) begin
      wait_r <= 4'h0;
      opt_rvalid <= 1'b0;
      opt_rdata <= ~opt_rdata;
    end else if (wait_r == dly) begin
      opt_rvalid <= 1'b1;
      opt_rdata <= word_at(opt_addr);
    end else begin
      wait_r <= wait_r + 4'h1;
      opt_rdata <= ~opt_rdata;
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the boot mode and option loader.
`timescale 1ns/1ns
module tb_top;
  import bmol_pkg::*;
  logic        mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        sel_pin, op_pin, dbg_pin, opt_rd, opt_rvalid, emu_on, board_sel, board_opt, emu_sel, emu_opt;
  logic        rom_en, ext_en;
  logic [31:0] awaddr, wdata, araddr, rdata, opt_addr, opt_rdata, wdt_w, sup_w, end_w, rdat, ew;
  logic [3:0]  wstrb, dly;
  logic [1:0]  bresp, rresp, resp;
  bmol_boot_t  boot_cfg;
  bmol_opt_t   opt_cfg;
  int          bad_count, n_tests, i;
  // Option words for the three boot runs; reserved bits are programmed as ones, except bit 0 of the second watchdog word.
  logic [31:0] wt[3] = '{32'hFFFF_FFFF, 32'hA5A5_5A58, 32'hFFFD_FFFF};
  logic [31:0] st[3] = '{32'hFFFF_FFFF, 32'hFFFF_FEFB, 32'hFFFF_FFFB};
  logic [31:0] et[3] = '{32'hFFFF_FFFF, 32'hFFFF_FFF8, 32'hFFFF_FFFF};
  bmol_mode_t  mx[3] = '{BM_SINGLE, BM_SERIAL, BM_USER};
  logic [31:0] vx[3] = '{SINGLE_VEC, SERIAL_VEC, USER_VEC};
  ////////////////////////////////////////
  bmol_loader bmol_loader_i (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .boot_mode_select_pin(sel_pin), .boot_option_port_pin(op_pin),
    .debug_enable_pin(dbg_pin), .opt_rd(opt_rd), .opt_addr(opt_addr), .opt_rdata(opt_rdata),
    .opt_rvalid(opt_rvalid), .boot_cfg(boot_cfg), .opt_cfg(opt_cfg), .onchip_rom_enable(rom_en),
    .external_bus_enable(ext_en));
  bmol_board_model bmol_board_model_i (
    .mclk(mclk), .rst(rst), .emu_on(emu_on), .board_sel(board_sel), .board_opt(board_opt), .emu_sel(emu_sel),
    .emu_opt(emu_opt), .wdt_word(wdt_w), .sup_word(sup_w), .end_word(end_w), .dly(dly), .opt_rd(opt_rd),
    .opt_addr(opt_addr), .boot_mode_select_pin(sel_pin), .boot_option_port_pin(op_pin),
    .debug_enable_pin(dbg_pin), .opt_rdata(opt_rdata), .opt_rvalid(opt_rvalid));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Ready levels are taken at the falling edge; they are registered, so they hold to the next rising edge.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic pa, pw, pb, ra, rw, rb;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw || pb) begin
      @(negedge mclk);
      ra = awready;
      rw = wready;
      rb = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (pa && ra) awvalid <= 1'b0;
      if (pw && rw) wvalid <= 1'b0;
      if (pb && rb) bready <= 1'b0;
      pa = pa && !ra;
      pw = pw && !rw;
      pb = pb && !rb;
    end
  endtask
  task automatic axi_rd(input logic [31:0] a);
    logic pa, pr, ra, rv;
    pa = 1'b1;
    pr = 1'b1;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pa || pr) begin
      @(negedge mclk);
      ra = arready;
      rv = rvalid;
      rdat = rdata;
      resp = rresp;
      @(posedge mclk);
      if (pa && ra) arvalid <= 1'b0;
      if (pr && rv) rready <= 1'b0;
      pa = pa && !ra;
      pr = pr && !rv;
    end
  endtask
  // Run k: single-chip with prompt flash, serial boot, then user boot forced by the emulator over the board.
  task automatic boot(input int k);
    int n;
    rst <= 1'b1;
    {wdt_w, sup_w, end_w} <= {wt[k], st[k], et[k]};
    dly <= 4'(3 * k);
    {emu_on, board_sel, board_opt, emu_sel, emu_opt} <= {k == 2, k != 1, k != 1, 2'b01};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    n = 0;
    while (boot_cfg.done !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk("boot done", 32'(boot_cfg.done), 32'h1);
  endtask
  task automatic ctl(input logic [31:0] d, input logic [1:0] e);
    axi_wr(SYSCTL_OFF, d);
    chk("control resp", 32'(resp), 32'(RESP_OKAY));
    @(negedge mclk);
    chk("control pins", {30'h0, ext_en, rom_en}, {30'h0, e});
    axi_rd(SYSCTL_OFF);
    chk("control read", rdat & 32'h0000_0003, {30'h0, e});
  endtask
  ////////////////////////////////////////
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, emu_on, board_sel, board_opt, emu_sel, emu_opt} = 11'h400;
    {awaddr, wdata, araddr, wdt_w, sup_w, end_w} = '0;
    wstrb = 4'hF;
    dly = 4'h0;
    for (i = 0; i < 3; i++) begin
      boot(i);
      chk("mode", 32'(boot_cfg.mode), 32'(mx[i]));
      chk("start vector", boot_cfg.start_vec, vx[i]);
      chk("user boot area writable", 32'(boot_cfg.boot_area_wr_en), 32'(i == 1));
      chk("big endian", 32'(boot_cfg.big_endian), 32'(et[i][2:0] == 3'h0));
      ew = {1'b0, ~wt[i][1], wt[i][16:2], ~wt[i][17], wt[i][31:18]};
      chk("watchdog cfg", 32'({opt_cfg.ind_wdt_start, opt_cfg.ind_wdt_set, opt_cfg.wdt_start,
                               opt_cfg.wdt_set}), ew);
      chk("supply cfg", 32'({opt_cfg.lv_mon_on, opt_cfg.fast_osc_on}), {30'h0, ~st[i][2], ~st[i][8]});
      axi_rd(STATUS_OFF);
      chk("status", rdat & 32'h0000_007F, {26'h0, 1'b1, i == 2, et[i][2:0] == 3'h0, 1'b1, mx[i]});
      axi_rd(WDT_OPT_OFF);
      chk("watchdog word", rdat, wt[i]);
      axi_rd(SUP_OPT_OFF);
      chk("supply word", rdat, st[i]);
      axi_rd(ENDIAN_ADDR);
      chk("endian word", rdat, et[i]);
      {board_sel, board_opt, emu_sel, emu_opt} <= {~board_sel, ~board_opt, 2'b10};
      repeat (10) @(posedge mclk);
      chk("mode held", 32'(boot_cfg.mode), 32'(mx[i]));
      $display("test boot run %0d done", i);
    end
    ctl(32'h0000_0003, 2'h3);
    ctl(32'h0000_0002, 2'h2);
    ctl(32'h0000_0003, 2'h2);
    ctl(32'h0000_0001, 2'h0);
    axi_wr(32'h0000_0100, 32'h0000_0003);
    chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
    axi_rd(32'h0000_0100);
    chk("unmapped read resp", 32'(resp), 32'(RESP_SLVERR));
    chk("unmapped read data", rdat, 32'h0000_0000);
    // A write with lane zero masked and a write to the status word must both be answered and ignored.
    wstrb <= 4'h0;
    axi_wr(SYSCTL_OFF, 32'h0000_0002);
    wstrb <= 4'hF;
    chk("masked write resp", 32'(resp), 32'(RESP_OKAY));
    axi_wr(STATUS_OFF, 32'hFFFF_FFFF);
    chk("status write resp", 32'(resp), 32'(RESP_OKAY));
    @(negedge mclk);
    chk("masked write pins", {30'h0, ext_en, rom_en}, 32'h0000_0000);
    $display("test control word done");
    boot(0);
    chk("control after reset", {30'h0, ext_en, rom_en}, 32'h0000_0001);
    $display("test second reset done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] run length expected finish seen timeout");
    close_out();
  end
endmodule
